// ===== src/console_pkg.sv
// shared constants and types for the operator console
`default_nettype none
package console_pkg;
  // -------------------------------------------------------------
  // widths and counts
  // -------------------------------------------------------------
  localparam int DATA_W = 18;
  localparam int ADDR_W = 15;
  localparam int SEL_W = 4;
  localparam int GROUP_REGS = 12;
  localparam int CABLE_REGS = 24;
  localparam int CTRL_FUNCS = 34;
  localparam int CABLE_SLOTS = CABLE_REGS + 2;
  localparam int SLOT_W = 5;
  localparam int KEYS = 10;
  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int DEBOUNCE_US = 5000;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int DB_W = 16;
  // -------------------------------------------------------------
  // register port
  // -------------------------------------------------------------
  localparam int BUS_AW = 8;
  localparam int BUS_DW = 32;
  localparam logic [BUS_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [BUS_AW-1:0] REG_STATUS = 8'h04;
  localparam logic [BUS_AW-1:0] REG_SWITCH = 8'h08;
  localparam int CTRL_LOCK_BIT = 0;
  localparam logic CTRL_LOCK_RST = 1'b0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_KEY_LSB = 3;
  localparam int STAT_STOPPED_BIT = 13;
  localparam int STAT_HALTED_BIT = 14;
  // -------------------------------------------------------------
  // types
  // -------------------------------------------------------------
  typedef struct packed {
    logic examine_next;
    logic examine;
    logic deposit_next;
    logic deposit;
    logic read_in;
    logic reset;
    logic stop;
    logic cont;
    logic execute;
    logic start;
  } key_s;

  typedef struct packed {
    logic single_instr;
    logic single_step;
    logic single_time;
    logic halt_loop;
    logic repeat_sw;
    logic parity_off;
    logic clock_off;
    logic reg_group;
  } mode_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT_HALT = 3'h2,
    ST_WAIT_TICK = 3'h4
  } rep_state_e;
endpackage : console_pkg
`default_nettype wire

// ===== src/operator_console_control.sv
// operator console: switches, keys, repeat, stepping, display cable
//
// The plain strobed port and the register offsets were chosen for this implementation.
`default_nettype none
module operator_console_control #(
  parameter int DEBOUNCE_CYC = console_pkg::DEBOUNCE_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [console_pkg::DATA_W-1:0] data_sw_i,
  input wire logic [console_pkg::ADDR_W-1:0] addr_sw_i,
  input wire logic [console_pkg::SEL_W-1:0] reg_sel_i,
  input wire console_pkg::mode_s mode_sw_i,
  input wire console_pkg::key_s key_raw_i,
  input wire logic repeat_tick_i,
  input wire logic cpu_halted_i,
  input wire logic oas_strobe_i,
  input wire logic [console_pkg::DATA_W-1:0] acc_i,
  input wire logic [console_pkg::ADDR_W-1:0] operand_pointer_i,
  input wire logic rtc_pi_req_i,
  input wire logic parity_pi_req_i,
  input wire logic [console_pkg::DATA_W-1:0] regs_i [console_pkg::CABLE_REGS],
  input wire logic [console_pkg::CTRL_FUNCS-1:0] ctrl_funcs_i,
  input wire logic [console_pkg::BUS_AW-1:0] addr_i,
  input wire logic [console_pkg::BUS_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [console_pkg::BUS_DW-1:0] rdata_o,
  output logic [console_pkg::DATA_W-1:0] or_switches_into_accumulator_o,
  output logic [console_pkg::DATA_W-1:0] deposit_data_o,
  output logic [console_pkg::ADDR_W-1:0] memory_address_register_o,
  output logic mar_load_o,
  output console_pkg::key_s key_cmd_o,
  output logic [console_pkg::ADDR_W-1:0] deposit_next_addr_o,
  output logic halt_at_instr_end_o,
  output logic halt_after_time_o,
  output logic halt_after_major_o,
  output logic halt_after_instr_o,
  output logic halt_loop_o,
  output logic rtc_program_interrupt_o,
  output logic parity_program_interrupt_o,
  output logic [console_pkg::DATA_W-1:0] reg_display_o,
  output logic [console_pkg::DATA_W-1:0] cable_data_o,
  output logic [console_pkg::SLOT_W-1:0] cable_slot_o
);
  import console_pkg::*;

  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  if (DEBOUNCE_CYC < 1 || DEBOUNCE_CYC >= (1 << DB_W)) begin : g_chk
    $error("debounce count out of range");
  end

  localparam logic [DB_W-1:0] DB_LAST = DB_W'(DEBOUNCE_CYC - 1);

  function automatic logic loads_mar(input key_s k);
    loads_mar = k.start | k.read_in | k.examine | k.deposit;
  endfunction : loads_mar

  function automatic logic repeatable(input key_s k);
    repeatable = k.start | k.execute | k.cont | k.deposit |
                 k.deposit_next | k.examine_next;
  endfunction : repeatable

  // ---------------------------------------------------------------
  // switch synchronisers
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] data_meta_r, data_r;
  logic [ADDR_W-1:0] addr_meta_r, addr_r;
  logic [SEL_W-1:0] sel_meta_r, sel_r;
  mode_s mode_meta_r, mode_r;
  logic tick_meta_r, tick_r, halted_meta_r, halted_r;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      data_meta_r <= '0;
      data_r <= '0;
      addr_meta_r <= '0;
      addr_r <= '0;
      sel_meta_r <= '0;
      sel_r <= '0;
      mode_meta_r <= '0;
      mode_r <= '0;
      tick_meta_r <= 1'b0;
      tick_r <= 1'b0;
      halted_meta_r <= 1'b0;
      halted_r <= 1'b0;
    end else begin
      data_meta_r <= data_sw_i;
      data_r <= data_meta_r;
      addr_meta_r <= addr_sw_i;
      addr_r <= addr_meta_r;
      sel_meta_r <= reg_sel_i;
      sel_r <= sel_meta_r;
      mode_meta_r <= mode_sw_i;
      mode_r <= mode_meta_r;
      tick_meta_r <= repeat_tick_i;
      tick_r <= tick_meta_r;
      halted_meta_r <= cpu_halted_i;
      halted_r <= halted_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // key debounce
  // ---------------------------------------------------------------
  logic [KEYS-1:0] key_meta_r, key_sync_r, key_stable_r, key_stable_nxt;
  logic [KEYS-1:0] press_r, press_nxt;
  logic [DB_W-1:0] db_cnt_r [KEYS];
  logic [DB_W-1:0] db_cnt_nxt [KEYS];
  key_s press_k;

  assign press_k = key_s'(press_r);

  for (genvar k = 0; k < KEYS; k++) begin : g_key
    always_comb begin
      db_cnt_nxt[k] = '0;
      key_stable_nxt[k] = key_stable_r[k];
      if (key_sync_r[k] != key_stable_r[k]) begin
        db_cnt_nxt[k] = db_cnt_r[k] + DB_W'(1);
        if (db_cnt_r[k] == DB_LAST) begin
          db_cnt_nxt[k] = '0;
          key_stable_nxt[k] = key_sync_r[k];
        end
      end
      press_nxt[k] = key_stable_nxt[k] & ~key_stable_r[k];
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        key_meta_r[k] <= 1'b0;
        key_sync_r[k] <= 1'b0;
        key_stable_r[k] <= 1'b0;
        db_cnt_r[k] <= '0;
        press_r[k] <= 1'b0;
      end else begin
        key_meta_r[k] <= key_raw_i[k];
        key_sync_r[k] <= key_meta_r[k];
        key_stable_r[k] <= key_stable_nxt[k];
        db_cnt_r[k] <= db_cnt_nxt[k];
        press_r[k] <= press_nxt[k];
      end
    end
  end

  // ---------------------------------------------------------------
  // key action and repeat control
  // ---------------------------------------------------------------
  rep_state_e state_r, state_nxt;
  key_s cur_key_r, cur_key_nxt, cmd_r, cmd_nxt;
  logic mar_load_r, mar_load_nxt, stopped_r, stopped_nxt, lock_r, lock_nxt;
  logic ran_r, ran_nxt;
  logic [ADDR_W-1:0] mar_r, mar_nxt;
  key_s go;

  always_comb begin
    state_nxt = state_r;
    cur_key_nxt = cur_key_r;
    cmd_nxt = '0;
    mar_load_nxt = 1'b0;
    mar_nxt = mar_r;
    stopped_nxt = stopped_r;
    go = '0;
    if (press_r != '0 && !lock_r) begin
      go = press_k;
    end
    unique case (state_r)
      ST_IDLE: begin
        if (go != '0) begin
          cmd_nxt = go;
          if (!go.stop && mode_r.repeat_sw && repeatable(go)) begin
            cur_key_nxt = go;
            state_nxt = (go.start || go.cont) ? ST_WAIT_HALT
                                               : ST_WAIT_TICK;
          end
        end
      end
      ST_WAIT_HALT: begin
        if (halted_r && ran_r) begin
          state_nxt = ST_WAIT_TICK;
        end
      end
      ST_WAIT_TICK: begin
        if (tick_r) begin
          cmd_nxt = cur_key_r;
          state_nxt = (cur_key_r.start || cur_key_r.cont) ? ST_WAIT_HALT
                                                           : ST_WAIT_TICK;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (state_r != ST_IDLE && (go.stop || !mode_r.repeat_sw)) begin
      state_nxt = ST_IDLE;
      cur_key_nxt = '0;
      cmd_nxt = go.stop ? go : '0;
    end
    // processor must be seen running before a halt counts
    ran_nxt = 1'b0;
    if (state_r == ST_WAIT_HALT && state_nxt == ST_WAIT_HALT) begin
      ran_nxt = ran_r | ~halted_r;
    end
    if (loads_mar(cmd_nxt)) begin
      mar_load_nxt = 1'b1;
      mar_nxt = addr_r;
    end
    if (cmd_nxt.stop) begin
      stopped_nxt = 1'b1;
    end else if (cmd_nxt.start || cmd_nxt.cont || cmd_nxt.execute ||
                 cmd_nxt.read_in) begin
      stopped_nxt = 1'b0;
    end
    lock_nxt = lock_r;
    if (wr_i && addr_i == REG_CTRL) begin
      lock_nxt = wdata_i[CTRL_LOCK_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= ST_IDLE;
      cur_key_r <= '0;
      cmd_r <= '0;
      mar_load_r <= 1'b0;
      mar_r <= '0;
      stopped_r <= 1'b0;
      lock_r <= CTRL_LOCK_RST;
      ran_r <= 1'b0;
    end else begin
      ran_r <= ran_nxt;
      state_r <= state_nxt;
      cur_key_r <= cur_key_nxt;
      cmd_r <= cmd_nxt;
      mar_load_r <= mar_load_nxt;
      mar_r <= mar_nxt;
      stopped_r <= stopped_nxt;
      lock_r <= lock_nxt;
    end
  end

  // ---------------------------------------------------------------
  // datapath, modes, interrupt gates, display
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] oas_r, oas_nxt, disp_r, disp_nxt, cable_r, cable_nxt;
  logic [ADDR_W-1:0] dnext_r, dnext_nxt;
  logic rtc_r, rtc_nxt, par_r, par_nxt;
  logic [SLOT_W-1:0] slot_r, slot_nxt;
  logic [SEL_W:0] disp_idx;
  logic [BUS_DW-1:0] rdata_r, rdata_nxt;

  always_comb begin
    oas_nxt = oas_r;
    if (oas_strobe_i) begin
      oas_nxt = acc_i | data_r;
    end
    dnext_nxt = operand_pointer_i + ADDR_W'(1);
    rtc_nxt = rtc_pi_req_i & ~mode_r.clock_off;
    par_nxt = parity_pi_req_i & ~mode_r.parity_off;
    disp_idx = mode_r.reg_group ? (SEL_W + 1)'(GROUP_REGS) + {1'b0, sel_r}
                                : {1'b0, sel_r};
    disp_nxt = '0;
    if (sel_r < SEL_W'(GROUP_REGS)) begin
      disp_nxt = regs_i[disp_idx];
    end
    slot_nxt = (slot_r == SLOT_W'(CABLE_SLOTS - 1)) ? '0
                                                   : slot_r + SLOT_W'(1);
    if (slot_r < SLOT_W'(CABLE_REGS)) begin
      cable_nxt = regs_i[slot_r];
    end else if (slot_r == SLOT_W'(CABLE_REGS)) begin
      cable_nxt = ctrl_funcs_i[DATA_W-1:0];
    end else begin
      cable_nxt = DATA_W'(ctrl_funcs_i[CTRL_FUNCS-1:DATA_W]);
    end
    rdata_nxt = '0;
    if (rd_i) begin
      unique case (addr_i)
        REG_CTRL: rdata_nxt[CTRL_LOCK_BIT] = lock_r;
        REG_STATUS: begin
          rdata_nxt[STAT_STATE_LSB +: 3] = state_r;
          rdata_nxt[STAT_KEY_LSB +: KEYS] = cur_key_r;
          rdata_nxt[STAT_STOPPED_BIT] = stopped_r;
          rdata_nxt[STAT_HALTED_BIT] = halted_r;
        end
        REG_SWITCH: rdata_nxt[DATA_W-1:0] = data_r;
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      oas_r <= '0;
      dnext_r <= '0;
      rtc_r <= 1'b0;
      par_r <= 1'b0;
      disp_r <= '0;
      slot_r <= '0;
      cable_r <= '0;
      rdata_r <= '0;
    end else begin
      oas_r <= oas_nxt;
      dnext_r <= dnext_nxt;
      rtc_r <= rtc_nxt;
      par_r <= par_nxt;
      disp_r <= disp_nxt;
      slot_r <= slot_nxt;
      cable_r <= cable_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign or_switches_into_accumulator_o = oas_r;
  assign deposit_data_o = data_r;
  assign memory_address_register_o = mar_r;
  assign mar_load_o = mar_load_r;
  assign key_cmd_o = cmd_r;
  assign deposit_next_addr_o = dnext_r;
  assign halt_at_instr_end_o = stopped_r;
  assign halt_after_time_o = mode_r.single_time;
  assign halt_after_major_o = mode_r.single_step;
  assign halt_after_instr_o = mode_r.single_instr;
  assign halt_loop_o = mode_r.halt_loop &
                       (mode_r.single_time | mode_r.single_step |
                        mode_r.single_instr);
  assign rtc_program_interrupt_o = rtc_r;
  assign parity_program_interrupt_o = par_r;
  assign reg_display_o = disp_r;
  assign cable_data_o = cable_r;
  assign cable_slot_o = slot_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_tick_wait;
    state_r == ST_WAIT_TICK && tick_r && mode_r.repeat_sw && go == '0;
  endsequence
  property p_repeat_issue;
    s_tick_wait |=> key_cmd_o == $past(cur_key_r);
  endproperty
  a_repeat_issue: assert property (p_repeat_issue)
    else $error("repeat tick did not reissue key");
  property p_oas;
    oas_strobe_i |=> or_switches_into_accumulator_o == $past(acc_i | data_r);
  endproperty
  a_oas: assert property (p_oas)
    else $error("switch merge value wrong");
  property p_mar;
    mar_load_o |-> loads_mar(key_cmd_o) &&
                   memory_address_register_o == $past(addr_r);
  endproperty
  a_mar: assert property (p_mar)
    else $error("address load mismatch");
  property p_rtc;
    mode_r.clock_off |=> !rtc_program_interrupt_o;
  endproperty
  a_rtc: assert property (p_rtc)
    else $error("clock interrupt not blocked");
  property p_par;
    parity_pi_req_i && !mode_r.parity_off |=> parity_program_interrupt_o;
  endproperty
  a_par: assert property (p_par)
    else $error("parity interrupt gate wrong");
  property p_stop;
    (press_k.stop && !lock_r) |=> state_r == ST_IDLE ##0 key_cmd_o.stop
                                  ##1 halt_at_instr_end_o;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop key did not end repeat");
  property p_rep_off;
    !mode_r.repeat_sw |=> state_r == ST_IDLE;
  endproperty
  a_rep_off: assert property (p_rep_off)
    else $error("repeat continued with switch off");
  property p_press_once;
    press_r != '0 |=> press_r == '0;
  endproperty
  a_press_once: assert property (p_press_once)
    else $error("key press longer than one cycle");
  property p_start_waits;
    state_r == ST_WAIT_HALT && !halted_r && mode_r.repeat_sw && go == '0
      |=> key_cmd_o == '0;
  endproperty
  a_start_waits: assert property (p_start_waits)
    else $error("restart issued before halt");
endmodule : operator_console_control
`default_nettype wire

// ===== verif/cpu_model.sv
// processor stand-in: run and halt status, register sources
`default_nettype none
module cpu_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire console_pkg::key_s key_cmd_i,
  output logic cpu_halted_o,
  output logic [console_pkg::DATA_W-1:0] regs_o [console_pkg::CABLE_REGS]
);
  timeunit 1ns;
  timeprecision 1ns;
  int run_cnt;
  // -------------------------------------------------------------
  // register sources
  // -------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < console_pkg::CABLE_REGS; i++) begin
      regs_o[i] = 18'(i * 18'h00421 + 18'h10000);
    end
  end
  // -------------------------------------------------------------
  // one instruction of six cycles per run command, then halt
  // -------------------------------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_cnt <= 0;
    end else if (key_cmd_i.start || key_cmd_i.cont || key_cmd_i.execute) begin
      run_cnt <= 6;
    end else if (run_cnt != 0) begin
      run_cnt <= run_cnt - 1;
    end
  end
  assign cpu_halted_o = (run_cnt == 0);
endmodule : cpu_model
`default_nettype wire

// ===== verif/operator_console_control_test.sv
// self-checking bench for the operator console
`default_nettype none
module operator_console_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] mode;
    logic [3:0] sel;
    logic [4:0] idx;
    logic [1:0] pi;
    logic [3:0] halt;
  } row_s;
  localparam row_s ROWS [11] = '{
    '{8'h00, 4'h3, 5'h03, 2'h3, 4'h0}, '{8'h01, 4'h3, 5'h0F, 2'h3, 4'h0},
    '{8'h01, 4'hB, 5'h17, 2'h3, 4'h0}, '{8'h00, 4'hD, 5'h1F, 2'h3, 4'h0},
    '{8'h02, 4'h0, 5'h00, 2'h1, 4'h0}, '{8'h04, 4'h0, 5'h00, 2'h2, 4'h0},
    '{8'h30, 4'h0, 5'h00, 2'h3, 4'h9}, '{8'h50, 4'h0, 5'h00, 2'h3, 4'hA},
    '{8'h90, 4'h0, 5'h00, 2'h3, 4'hC}, '{8'h10, 4'h0, 5'h00, 2'h3, 4'h0},
    '{8'h20, 4'h0, 5'h00, 2'h3, 4'h1}};
  localparam logic [9:0] MLOAD = 10'h161;
  localparam int RK [5] = '{6, 7, 9, 1, 8};
  logic clk_i, sys_rst_i, tick, halted, or_switches_into_accumulator, rd, wr, rtc_req, par_req;
  logic rtc_pi, par_pi, mar_load, halt_end, h_time, h_major, h_instr, h_loop;
  logic [17:0] data_sw, acc, disp, dep_data, or_sw, cable_data;
  logic [17:0] regs [24];
  logic [14:0] addr_sw, op_ptr, mar, dn_addr;
  logic [33:0] ctrl;
  logic [31:0] wdata, rdata;
  logic [7:0] addr;
  logic [4:0] slot;
  logic [3:0] reg_sel;
  console_pkg::mode_s mode_sw;
  console_pkg::key_s key_raw, key_cmd;
  int num_errors, compares;
  // -------------------------------------------------------------
  // design and processor stand-in
  // -------------------------------------------------------------
  operator_console_control #(.DEBOUNCE_CYC(4)) u_operator_console_control (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .data_sw_i(data_sw),
    .addr_sw_i(addr_sw), .reg_sel_i(reg_sel), .mode_sw_i(mode_sw),
    .key_raw_i(key_raw), .repeat_tick_i(tick), .cpu_halted_i(halted),
    .oas_strobe_i(or_switches_into_accumulator), .acc_i(acc), .operand_pointer_i(op_ptr),
    .rtc_pi_req_i(rtc_req), .parity_pi_req_i(par_req), .regs_i(regs),
    .ctrl_funcs_i(ctrl), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .or_switches_into_accumulator_o(or_sw),
    .deposit_data_o(dep_data), .memory_address_register_o(mar),
    .mar_load_o(mar_load), .key_cmd_o(key_cmd),
    .deposit_next_addr_o(dn_addr), .halt_at_instr_end_o(halt_end),
    .halt_after_time_o(h_time), .halt_after_major_o(h_major),
    .halt_after_instr_o(h_instr), .halt_loop_o(h_loop),
    .rtc_program_interrupt_o(rtc_pi), .parity_program_interrupt_o(par_pi),
    .reg_display_o(disp), .cable_data_o(cable_data), .cable_slot_o(slot));
  cpu_model u_cpu_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .key_cmd_i(key_cmd), .cpu_halted_o(halted), .regs_o(regs));
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic logic [17:0] rv(input int i);
    return 18'(i * 18'h00421 + 18'h10000);
  endfunction : rv
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd <= 1'b0;
    @(negedge clk_i);
    d = rdata;
  endtask : reg_rd
  task automatic see(input int n, output logic [10:0] f, output int c);
    f = '0;
    c = 0;
    repeat (n) begin
      @(negedge clk_i);
      if (key_cmd !== 10'h000) begin
        if (c == 0) f = {mar_load, key_cmd};
        c++;
      end
    end
  endtask : see
  task automatic press(input logic [9:0] k, output logic [10:0] f,
                       output int c);
    logic [10:0] f2;
    int c2;
    @(posedge clk_i);
    key_raw <= k;
    see(20, f, c);
    @(posedge clk_i);
    key_raw <= '0;
    see(12, f2, c2);
    c += c2;
  endtask : press
  task automatic pulse_tick(output logic [10:0] f, output int c);
    cyc(8);
    tick <= 1'b1;
    @(posedge clk_i);
    tick <= 1'b0;
    see(8, f, c);
  endtask : pulse_tick
  // -------------------------------------------------------------
  // clock and watchdog
  // -------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    #2_000_000;
    num_errors++;
    tally_and_finish();
  end
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    logic [10:0] f;
    logic [31:0] d;
    logic [9:0] k;
    int c, s;
    {tick, or_switches_into_accumulator, rd, wr} = '0;
    {rtc_req, par_req} = 2'b11;
    data_sw = 18'h2A5C3;
    acc = 18'h10101;
    addr_sw = 15'h5A5A;
    op_ptr = 15'h7FFE;
    ctrl = 34'h2ABCD1234;
    {wdata, addr, reg_sel} = '0;
    mode_sw = '0;
    key_raw = '0;
    sys_rst_i = 1'b1;
    cyc(5);
    @(negedge clk_i);
    check({halt_end, mar_load, key_cmd, rdata}, 0);
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    foreach (ROWS[i]) begin
      @(posedge clk_i);
      mode_sw <= ROWS[i].mode;
      reg_sel <= ROWS[i].sel;
      cyc(5);
      @(negedge clk_i);
      check(disp, ROWS[i].idx == 31 ? 18'h0 : rv(ROWS[i].idx));
      check({rtc_pi, par_pi}, ROWS[i].pi);
      check({h_loop, h_instr, h_major, h_time}, ROWS[i].halt);
    end
    foreach (ROWS[i]) if (i < 2) begin
      @(posedge clk_i);
      data_sw <= i ? 18'h3FFFF : 18'h05A3C;
      mode_sw <= '0;
      cyc(4);
      or_switches_into_accumulator <= 1'b1;
      @(posedge clk_i);
      or_switches_into_accumulator <= 1'b0;
      cyc(2);
      @(negedge clk_i);
      check(or_sw, acc | data_sw);
      check(dep_data, data_sw);
      check(dn_addr, 15'h7FFF);
    end
    reg_rd(8'h04, d);
    check(d, 32'h00004001);
    reg_rd(8'h08, d);
    check(d, 32'h0003FFFF);
    reg_rd(8'h0C, d);
    check(d, 32'h0);
    for (int i = 0; i < 10; i++) begin
      k = 10'(1 << i);
      @(posedge clk_i);
      addr_sw <= 15'(i * 15'h0C35 + 15'h0001);
      press(k, f, c);
      check(f, {MLOAD[i], k});
      check(c, 1);
      if (MLOAD[i]) check(mar, 15'(i * 15'h0C35 + 15'h0001));
      if (i == 3) check(halt_end, 1'b1);
      if (i == 2) check(halt_end, 1'b0);
    end
    reg_wr(8'h00, 32'h1);
    press(10'h001, f, c);
    check(c, 0);
    reg_wr(8'h00, 32'h0);
    foreach (RK[i]) begin
      k = 10'(1 << RK[i]);
      @(posedge clk_i);
      mode_sw <= 8'h08;
      cyc(4);
      press(k, f, c);
      check(f, {MLOAD[RK[i]], k});
      repeat (2) begin
        pulse_tick(f, c);
        check(f, RK[i] == 8 ? 11'h0 : {MLOAD[RK[i]], k});
      end
      @(posedge clk_i);
      mode_sw <= '0;
      cyc(4);
      pulse_tick(f, c);
      check(c, 0);
    end
    @(posedge clk_i);
    mode_sw <= 8'h08;
    for (int i = 0; i < 3; i += 2) begin
      k = 10'(1 << i);
      press(k, f, c);
      pulse_tick(f, c);
      check(f, {MLOAD[i], k});
      pulse_tick(f, c);
      check(f, {MLOAD[i], k});
      press(10'h008, f, c);
      check(f, 11'h008);
      pulse_tick(f, c);
      check(c, 0);
    end
    s = -1;
    repeat (60) begin
      @(negedge clk_i);
      if (s >= 0) begin
        check(cable_data, s < 24 ? rv(s) : s == 24 ? ctrl[17:0] : ctrl[33:18]);
        check(slot, s == 25 ? 0 : s + 1);
      end
      s = int'(slot);
    end
    tally_and_finish();
  end
endmodule : operator_console_control_test
`default_nettype wire
